// ===== core/sfi_ctl.sv
// controller end: turns step requests into timed enable/dir/step pins
// assumes requests come from logic on mclk; one request at a time
`timescale 1ns/10ps
module sfi_ctl (
  input  wire logic mclk,
  input  wire logic rst_b,
  sfi_link_if.ctl   link,
  input  wire logic enable_req,   // level: drive enabled
  input  wire logic step_req,     // pulse: one step wanted
  input  wire logic step_dir_req, // direction for that step
  output logic      step_busy,    // high while a step is in flight
  output logic      step_done     // one-cycle pulse at step end
);
  sfi_pkg::sfi_ctl_state_t state;
  logic [15:0] cnt;        // cycles spent in current phase
  logic [15:0] ena_age;    // cycles since enable rose, saturating
  logic        ena;
  logic        dir;
  logic        step;

  // the lead for each phase; long-enough wait opens the gate
  wire ena_ready = (ena_age >= 16'(sfi_pkg::ENA_LEAD_CYC));
  wire dir_ready = (cnt >= 16'(sfi_pkg::DIR_SETUP_CYC - 1));
  wire hi_done   = (cnt >= 16'(sfi_pkg::STEP_HIGH_CYC - 1));
  wire lo_done   = (cnt >= 16'(sfi_pkg::STEP_LOW_CYC - 1));

  // enable age tracking; dropping enable restarts the lead
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ena     <= 1'b0;
      ena_age <= 16'h0;
    end else begin
      ena     <= enable_req;
      if (!enable_req) ena_age <= 16'h0;
      else if (!ena_ready) ena_age <= ena_age + 16'h1;
    end
  end

  // step sequencer: dir setup, high, low, then idle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= sfi_pkg::SFI_CS_IDLE;
      cnt       <= 16'h0;
      dir       <= 1'b0;
      step      <= 1'b0;
      step_busy <= 1'b0;
      step_done <= 1'b0;
    end else begin
      step_done <= 1'b0;
      cnt       <= cnt + 16'h1;
      case (state)
        sfi_pkg::SFI_CS_IDLE: begin
          cnt <= 16'h0;
          // direction changes only once enable has led by 5 us
          if (step_req && ena_ready) begin
            dir       <= step_dir_req;
            step_busy <= 1'b1;
            state     <= sfi_pkg::SFI_CS_DIR;
          end
        end
        sfi_pkg::SFI_CS_DIR: begin
          if (dir_ready) begin
            step  <= 1'b1;
            cnt   <= 16'h0;
            state <= sfi_pkg::SFI_CS_HIGH;
          end
        end
        sfi_pkg::SFI_CS_HIGH: begin
          if (hi_done) begin
            step  <= 1'b0;
            cnt   <= 16'h0;
            state <= sfi_pkg::SFI_CS_LOW;
          end
        end
        sfi_pkg::SFI_CS_LOW: begin
          if (lo_done) begin
            step_busy <= 1'b0;
            step_done <= 1'b1;
            state     <= sfi_pkg::SFI_CS_IDLE;
          end
        end
        default: state <= sfi_pkg::SFI_CS_IDLE;
      endcase
    end
  end

  // pins straight from flip-flops
  assign link.drive_enable_in = ena;
  assign link.dir_in          = dir;
  assign link.step_pulse_in   = step;
endmodule : sfi_ctl

// ===== core/sfi_drive.sv
// drive end: samples step inputs, latches faults, flashes the red indicator
// assumes fault inputs are asynchronous levels from analog comparators
`timescale 1ns/10ps
module sfi_drive #(
  parameter longint unsigned PERIOD_CYC = sfi_pkg::IND_PERIOD_CYC, // indication period
  parameter longint unsigned SLOT_CYC   = sfi_pkg::FLASH_SLOT_CYC, // flash half length
  parameter int unsigned     POS_W      = 32                        // position counter width
) (
  input  wire logic            mclk,
  input  wire logic            rst_b,
  sfi_link_if.drv              link,
  input  wire logic            over_current_in,
  input  wire logic            over_voltage_in,
  input  wire logic            phase_error_in,
  output logic                 red_led,
  output logic                 motor_energise,
  output logic                 step_event,
  output logic                 step_dir,
  output logic signed [POS_W-1:0] position,
  output logic [1:0]           fault_code
);
  // two-stage synchronisers, first stage read only by second
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic       step_prev;   // last synchronised step level
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1     <= 6'h00;
      sync2     <= 6'h00;
      step_prev <= 1'b0;
    end else begin
      sync1     <= {phase_error_in, over_voltage_in, over_current_in,
                    link.drive_enable_in, link.dir_in, link.step_pulse_in};
      sync2     <= sync1;
      step_prev <= sync2[0];
    end
  end

  // named views of synchronised inputs
  wire step_s = sync2[0];
  wire dir_s  = sync2[1];
  wire ena_s  = sync2[2];
  wire oc_s   = sync2[3];
  wire ov_s   = sync2[4];
  wire ph_s   = sync2[5];

  // fault latch: no reset except rst_b, which stands for power-on
  sfi_pkg::sfi_fault_t fault;
  // priority pick; the first fault wins and later ones cannot displace it
  wire sfi_pkg::sfi_fault_t next_fault =
    (fault != sfi_pkg::SFI_FLT_NONE) ? fault :
    oc_s ? sfi_pkg::SFI_FLT_OC :
    ov_s ? sfi_pkg::SFI_FLT_OV :
    ph_s ? sfi_pkg::SFI_FLT_PH : sfi_pkg::SFI_FLT_NONE;
  wire faulted = (next_fault != sfi_pkg::SFI_FLT_NONE);

  // flashes wanted for the latched fault
  wire [2:0] flash_n =
    (fault == sfi_pkg::SFI_FLT_OC) ? sfi_pkg::FLASH_OVER_CURRENT :
    (fault == sfi_pkg::SFI_FLT_OV) ? sfi_pkg::FLASH_OVER_VOLTAGE :
    (fault == sfi_pkg::SFI_FLT_PH) ? sfi_pkg::FLASH_PHASE_ERROR : 3'h0;

  // period counter and slot counter; slots alternate on/off from period start
  logic [31:0] per_cnt;
  logic [31:0] slot_cnt;
  logic [3:0]  slot_idx;   // half-flash index within the period
  wire per_end   = (per_cnt == 32'(PERIOD_CYC - 1));
  wire slot_end  = (slot_cnt == 32'(SLOT_CYC - 1));
  // on during even slots while fewer than flash_n flashes shown
  wire led_on    = (fault != sfi_pkg::SFI_FLT_NONE) && !slot_idx[0] &&
                   (slot_idx[3:1] < flash_n);

  // indication timing; counters start fresh when the fault latches
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt  <= 32'h0;
      slot_cnt <= 32'h0;
      slot_idx <= 4'h0;
    end else if (fault == sfi_pkg::SFI_FLT_NONE || per_end) begin
      per_cnt  <= 32'h0;   // new period, flashes restart
      slot_cnt <= 32'h0;
      slot_idx <= 4'h0;
    end else begin
      per_cnt  <= per_cnt + 32'h1;
      slot_cnt <= slot_end ? 32'h0 : slot_cnt + 32'h1;
      // saturate so the rest of the period stays dark
      if (slot_end && slot_idx != 4'hf) begin
        slot_idx <= slot_idx + 4'h1;
      end
    end
  end

  // valid step: rising edge while enabled and not faulted
  wire step_ok = step_s && !step_prev && ena_s && !faulted;

  // registered outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fault          <= sfi_pkg::SFI_FLT_NONE;
      red_led        <= 1'b0;
      motor_energise <= 1'b0;
      step_event     <= 1'b0;
      step_dir       <= 1'b0;
      position       <= '0;
      fault_code     <= 2'h0;
    end else begin
      fault          <= next_fault;
      fault_code     <= next_fault;
      red_led        <= led_on;
      motor_energise <= ena_s && !faulted;
      step_event     <= step_ok;
      // direction was stable 5 us before edge by controller's duty
      if (step_ok) begin
        step_dir <= dir_s;
        position <= dir_s ? position + POS_W'(1) : position - POS_W'(1);
      end
    end
  end
endmodule : sfi_drive

// ===== core/sfi_link_if.sv
// interface joining the step controller and the drive
// assumes both ends sit on the same mclk; plain one-way wires only
`timescale 1ns/10ps
interface sfi_link_if;
  logic step_pulse_in;   // step pulse, active high
  logic dir_in;          // direction level
  logic drive_enable_in; // drive enable, high enables
  modport ctl (output step_pulse_in, output dir_in, output drive_enable_in);
  modport drv (input step_pulse_in, input dir_in, input drive_enable_in);
endinterface : sfi_link_if

// ===== core/sfi_pkg.sv
// package for the stepper fault indicator and step input link
// assumes a single 200 MHz clock shared by both ends of the link
package sfi_pkg;
  // clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  // indication period, 3 seconds, in milliseconds
  localparam int unsigned IND_PERIOD_MS  = 3000;
  localparam longint unsigned IND_PERIOD_CYC =
    (64'(IND_PERIOD_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);
  // one flash slot (on or off half), 150 ms
  localparam int unsigned FLASH_SLOT_MS  = 150;
  localparam longint unsigned FLASH_SLOT_CYC =
    (64'(FLASH_SLOT_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);
  // enable lead before direction, 5 us, rounded up
  localparam int unsigned ENA_LEAD_NS    = 5000;
  localparam int unsigned ENA_LEAD_CYC   = (ENA_LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // direction setup before step edge, 5 us, rounded up
  localparam int unsigned DIR_SETUP_NS   = 5000;
  localparam int unsigned DIR_SETUP_CYC  = (DIR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // step high and low widths, 2.5 us each, rounded up
  localparam int unsigned STEP_HIGH_NS   = 2500;
  localparam int unsigned STEP_HIGH_CYC  = (STEP_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STEP_LOW_NS    = 2500;
  localparam int unsigned STEP_LOW_CYC   = (STEP_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // flash counts per fault
  localparam logic [2:0] FLASH_OVER_CURRENT = 3'h1;
  localparam logic [2:0] FLASH_OVER_VOLTAGE = 3'h2;
  localparam logic [2:0] FLASH_PHASE_ERROR  = 3'h4;
  // latched fault codes
  typedef enum logic [1:0] {
    SFI_FLT_NONE = 2'h0,
    SFI_FLT_OC   = 2'h1,
    SFI_FLT_OV   = 2'h2,
    SFI_FLT_PH   = 2'h3
  } sfi_fault_t;
  // controller sequencer states
  typedef enum logic [1:0] {
    SFI_CS_IDLE = 2'h0,
    SFI_CS_DIR  = 2'h1,
    SFI_CS_HIGH = 2'h2,
    SFI_CS_LOW  = 2'h3
  } sfi_ctl_state_t;
endpackage : sfi_pkg

// ===== tb/sfi_link_assertions.sv
// link checker: enable, direction and step pin timing from the controller
// assumes one mclk domain, rst_b active low
`timescale 1ns/10ps
module sfi_link_assertions (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic step_pulse_in,
  input wire logic dir_in,
  input wire logic drive_enable_in
);
  logic [15:0] en_cnt;  // cycles enable has been high
  logic [15:0] dir_cnt; // cycles since direction moved
  logic [15:0] hi_cnt;  // cycles step high
  logic [15:0] lo_cnt;  // cycles step low
  logic        dir_q;   // direction one cycle ago
  wire         dir_mv = dir_in != dir_q; // direction moved this cycle
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // counters saturate so a long idle never wraps into a false failure
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {en_cnt, dir_cnt, hi_cnt, lo_cnt} <= '0;
      dir_q <= 1'b0;
    end else begin
      en_cnt  <= drive_enable_in ? en_cnt + {15'h0, &en_cnt == 1'b0} : 16'h0;
      dir_cnt <= dir_mv ? 16'h1 : dir_cnt + {15'h0, &dir_cnt == 1'b0};
      hi_cnt  <= step_pulse_in ? hi_cnt + {15'h0, &hi_cnt == 1'b0} : 16'h0;
      lo_cnt  <= !step_pulse_in ? lo_cnt + {15'h0, &lo_cnt == 1'b0} : 16'h0;
      dir_q   <= dir_in;
    end
  end
  sequence pulse_start;
    !step_pulse_in ##1 step_pulse_in;
  endsequence
  a_dir_after_enable: assert property (dir_mv |-> en_cnt >= sfi_pkg::ENA_LEAD_CYC)
    else $error("direction moved too soon after enable");
  a_dir_setup_time: assert property ($rose(step_pulse_in) |-> dir_cnt >= sfi_pkg::DIR_SETUP_CYC)
    else $error("direction setup before step too short");
  a_dir_held_high: assert property (step_pulse_in && $past(step_pulse_in) |-> $stable(dir_in))
    else $error("direction moved during step pulse");
  a_step_high_width: assert property ($fell(step_pulse_in) |-> hi_cnt >= sfi_pkg::STEP_HIGH_CYC)
    else $error("step high too short");
  a_pulse_body_held: assert property (pulse_start |=> step_pulse_in[*8])
    else $error("step pulse collapsed early");
  a_step_low_width: assert property ($rose(step_pulse_in) |-> lo_cnt >= sfi_pkg::STEP_LOW_CYC)
    else $error("step low too short");
endmodule : sfi_link_assertions

// ===== tb/stepper_fault_indicator_and_step_input_test.sv
// testbench: controller and drive joined by the link, steps then faults
// assumes short indication period 200 and slot 10 for speed
`timescale 1ns/10ps
module stepper_fault_indicator_and_step_input_test;
  logic mclk = 1'b0, rst_b = 1'b0, enable_req = 1'b0, step_req = 1'b0, step_dir_req = 1'b0;
  logic [2:0] flt = 3'h0; // current, voltage, phase
  logic step_busy, step_done, red_led, motor_energise, step_event, step_dir;
  logic signed [31:0] position;
  logic [1:0] fault_code;
  int n_errors = 0, checked = 0, n_ev = 0, i;
  logic row_dir[5] = '{1, 1, 0, 0, 0};      // step direction per row
  logic [31:0] row_pos[5] = '{1, 2, 1, 0, -1}; // position after row
  logic [2:0] f_in[5] = '{3'h4, 3'h2, 3'h1, 3'h3, 3'h7}; // fault inputs
  logic [1:0] f_code[5] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h1}; // code shown
  int f_n[5] = '{1, 2, 4, 2, 1}; // flashes per period
  sfi_link_if link ();
  sfi_ctl u_sfi_ctl (.mclk(mclk), .rst_b(rst_b), .link(link), .enable_req(enable_req),
    .step_req(step_req), .step_dir_req(step_dir_req), .step_busy(step_busy), .step_done(step_done));
  sfi_drive #(.PERIOD_CYC(200), .SLOT_CYC(10)) u_sfi_drive (.mclk(mclk), .rst_b(rst_b), .link(link),
    .over_current_in(flt[2]), .over_voltage_in(flt[1]), .phase_error_in(flt[0]),
    .red_led(red_led), .motor_energise(motor_energise), .step_event(step_event),
    .step_dir(step_dir), .position(position), .fault_code(fault_code));
  sfi_link_assertions u_sfi_link_assertions (.mclk(mclk), .rst_b(rst_b),
    .step_pulse_in(link.step_pulse_in), .dir_in(link.dir_in),
    .drive_enable_in(link.drive_enable_in));
  always #2.5 mclk = ~mclk;
  // one event pulse per counted step
  always @(posedge mclk) if (step_event === 1'b1) n_ev++;
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task print_verdict;
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task reset_dut;
    rst_b <= 1'b0;
    flt   <= 3'h0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
  endtask : reset_dut
  // hold the request until taken, then wait for completion
  task do_step(input logic d);
    int k;
    step_dir_req <= d;
    step_req     <= 1'b1;
    for (k = 0; k < 50 && step_busy !== 1'b1; k++) @(negedge mclk);
    @(posedge mclk) step_req <= 1'b0;
    for (k = 0; k < 5000 && step_done !== 1'b1; k++) @(negedge mclk);
    @(posedge mclk);
    chk("step_busy", 32'h0, {31'h0, step_busy});
  endtask : do_step
  // latch a fault, count flashes over one period, then prove the latch holds
  task fault(input logic [2:0] f, input logic [1:0] code, input int n);
    int k, rises, highs;
    logic prev;
    reset_dut();
    flt <= f;
    for (k = 0; k < 20 && fault_code === 2'h0; k++) @(negedge mclk);
    chk("fault_code", {30'h0, code}, {30'h0, fault_code});
    chk("energise", 32'h0, {31'h0, motor_energise});
    {rises, highs, prev} = '0;
    for (k = 0; k < 200; k++) begin
      @(negedge mclk);
      rises += (red_led === 1'b1 && prev !== 1'b1);
      highs += (red_led === 1'b1);
      prev = red_led;
    end
    chk("flashes", n, rises);
    chk("lit_cycles", n * 10, highs);
    @(posedge mclk) flt <= ~f;
    repeat (20) @(posedge mclk);
    chk("latched", {30'h0, code}, {30'h0, fault_code});
  endtask : fault
  initial begin
    reset_dut();
    enable_req <= 1'b1;
    repeat (1100) @(posedge mclk);
    for (i = 0; i < 5; i++) begin
      do_step(row_dir[i]);
      chk("position", row_pos[i], position);
      chk("step_dir", {31'h0, row_dir[i]}, {31'h0, step_dir});
    end
    chk("events", 32'h5, n_ev);
    chk("energise", 32'h1, {31'h0, motor_energise});
    for (i = 0; i < 5; i++) fault(f_in[i], f_code[i], f_n[i]);
    // a step sent while a fault is latched must not be counted
    repeat (1000) @(posedge mclk);
    do_step(1'b1);
    chk("faulted_events", 32'h5, n_ev);
    chk("faulted_position", 32'h0, position);
    reset_dut();
    repeat (10) @(posedge mclk);
    chk("cleared", 32'h0, {30'h0, fault_code});
    print_verdict();
  end
  // watchdog well beyond the expected 15300 cycles or so
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule : stepper_fault_indicator_and_step_input_test
